//--- core/mpls_label_stack_comparator.sv
// MPLS label stack comparator stage with register file and per-flow matchers
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module mpls_label_stack_comparator
    import mpls_cmp_pkg::*;
#(
    parameter int NUM_FLOWS = 8,
    parameter int NUM_CH = 4,
    parameter int CH_W = 2,
    parameter int OFF_W = 8
)(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [11:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic word_valid_in,
    input wire logic start_in,
    input wire logic last_in,
    input wire logic [WORD_W-1:0] word_in,
    input wire logic [CH_W-1:0] channel_in,
    input wire logic [OFF_W-1:0] base_offset_in,
    output logic result_valid_out,
    output logic [NUM_FLOWS-1:0] flow_match_out,
    output logic stack_error_out,
    output logic [2:0] label_count_out,
    output logic [OFF_W-1:0] next_offset_out,
    output logic [2:0] next_comparator_out,
    output logic next_set_out
);
    localparam int FI_W = (NUM_FLOWS > 1) ? $clog2(NUM_FLOWS) : 1;

    // Shared registers and per-flow register arrays
    logic match_mode_q;
    logic [2:0] next_cmp_q;
    logic [CTRL_W-1:0] ctrl_q [NUM_FLOWS];
    logic [LABEL_W-1:0] low_q [NUM_FLOWS][MAX_LABELS];
    logic [LABEL_W-1:0] high_q [NUM_FLOWS][MAX_LABELS];
    logic [31:0] rdata_q;

    // Parser state
    parse_state_t state_q;
    logic [LABEL_W-1:0] label_q [MAX_LABELS];
    logic [2:0] count_q;
    logic [3:0] cw_top_q;
    logic cw_seen_q;
    logic err_q;
    logic eval_q;
    logic [CH_W-1:0] chan_q;
    logic [OFF_W-1:0] base_q;

    // Decoded bus access
    wire in_flow = (reg_addr_in[11:FLOW_REGION_LSB] == FLOW_REGION);
    wire [FI_W-1:0] flow_idx = reg_addr_in[FLOW_IDX_LSB +: FI_W];
    wire [3:0] fword = reg_addr_in[5:2];
    wire flow_hit = in_flow && (int'(flow_idx) < NUM_FLOWS) && (fword <= FW_LAST);
    wire is_ctrl = flow_hit && (fword == FW_CTRL);
    wire is_low = flow_hit && (fword >= FW_LOW0) && (fword < FW_HIGH0);
    wire is_high = flow_hit && (fword >= FW_HIGH0);
    wire [1:0] low_k = 2'(fword - FW_LOW0);
    wire [1:0] high_k = 2'(fword - FW_HIGH0);

    // Stack word fields
    wire bos = word_in[BOS_BIT];
    wire [LABEL_W-1:0] word_label = word_in[LBL_MSB:LBL_LSB];
    wire at_max = (count_q == 3'(MAX_LABELS));
    wire start_word = word_valid_in && start_in;
    wire label_word = word_valid_in && !start_in && state_q == ST_LABELS;
    wire cw_word = word_valid_in && !start_in && state_q == ST_CTRLW;
    // A stack that runs past four labels or ends before a bottom label is bad
    wire over_depth = label_word && at_max;
    wire short_end = label_word && !at_max && !bos && last_in;
    wire final_lbl = (start_word || (label_word && !at_max)) && bos;
    wire go_eval = over_depth || short_end || cw_word || (final_lbl && last_in) ||
        (start_word && !bos && last_in);

    // Shared mode and pointer writes
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            match_mode_q <= MATCH_MODE_RST;
            next_cmp_q <= NEXT_CMP_RST;
        end
        else if (reg_wr_in && reg_addr_in == ADDR_MATCH_MODE)
            match_mode_q <= reg_wdata_in[0];
        else if (reg_wr_in && reg_addr_in == ADDR_NEXT_CMP)
            next_cmp_q <= reg_wdata_in[2:0];
    end

    // Every flow holds its own control word and label bounds; match mode is shared
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            for (int f = 0; f < NUM_FLOWS; f++)
            begin
                ctrl_q[f] <= CTRL_RST;
                for (int k = 0; k < MAX_LABELS; k++)
                begin
                    low_q[f][k] <= BOUND_LOW_RST;
                    high_q[f][k] <= BOUND_HIGH_RST;
                end
            end
        end
        else if (reg_wr_in)
        begin
            if (is_ctrl)
                ctrl_q[flow_idx] <= reg_wdata_in[CTRL_W-1:0];
            else if (is_low)
                low_q[flow_idx][low_k] <= reg_wdata_in[LABEL_W-1:0];
            else if (is_high)
                high_q[flow_idx][high_k] <= reg_wdata_in[LABEL_W-1:0];
        end
    end

    // Read mux; unmapped addresses read as zero
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (reg_addr_in == ADDR_MATCH_MODE)
            rd_mux = {31'h0, match_mode_q};
        else if (reg_addr_in == ADDR_NEXT_CMP)
            rd_mux = {29'h0, next_cmp_q};
        else if (reg_addr_in == ADDR_STATUS)
            rd_mux = {26'h0, state_q != ST_IDLE, err_q, cw_seen_q, count_q};
        else if (is_ctrl)
            rd_mux = {16'h0, ctrl_q[flow_idx]};
        else if (is_low)
            rd_mux = {12'h0, low_q[flow_idx][low_k]};
        else if (is_high)
            rd_mux = {12'h0, high_q[flow_idx][high_k]};
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rdata_q <= 32'h0000_0000;
        else if (reg_rd_in)
            rdata_q <= rd_mux;
    end
    assign reg_rdata_out = rdata_q;

    // Label walk: one word per valid cycle, stop on bottom-of-stack
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= ST_IDLE;
            count_q <= 3'h0;
            cw_top_q <= 4'h0;
            cw_seen_q <= 1'b0;
            err_q <= 1'b0;
            eval_q <= 1'b0;
            chan_q <= '0;
            base_q <= '0;
            for (int k = 0; k < MAX_LABELS; k++)
                label_q[k] <= '0;
        end
        else
        begin
            eval_q <= go_eval;
            if (start_word)
            begin
                label_q[0] <= word_label;
                count_q <= 3'h1;
                cw_seen_q <= 1'b0;
                err_q <= !bos && last_in;
                chan_q <= channel_in;
                base_q <= base_offset_in;
                state_q <= last_in ? ST_IDLE : (bos ? ST_CTRLW : ST_LABELS);
            end
            else if (label_word)
            begin
                if (at_max || (!bos && last_in))
                begin
                    err_q <= 1'b1;
                    state_q <= ST_IDLE;
                end
                else
                begin
                    label_q[count_q[1:0]] <= word_label;
                    count_q <= count_q + 3'h1;
                    if (bos)
                        state_q <= last_in ? ST_IDLE : ST_CTRLW;
                end
            end
            else if (cw_word)
            begin
                // Word after the final label is kept for flows expecting a control word
                cw_top_q <= word_in[CW_TOP_MSB:CW_TOP_LSB];
                cw_seen_q <= 1'b1;
                state_q <= ST_IDLE;
            end
        end
    end

    // Per-flow matchers
    logic [NUM_FLOWS-1:0] raw_match;
    logic [MAX_LABELS*LABEL_W-1:0] labels_flat;
    always_comb
    begin
        for (int k = 0; k < MAX_LABELS; k++)
            labels_flat[k*LABEL_W +: LABEL_W] = label_q[k];
    end

    for (genvar f = 0; f < NUM_FLOWS; f++)
    begin : g_flow
        logic [MAX_LABELS*LABEL_W-1:0] lo_flat;
        logic [MAX_LABELS*LABEL_W-1:0] hi_flat;
        always_comb
        begin
            for (int k = 0; k < MAX_LABELS; k++)
            begin
                lo_flat[k*LABEL_W +: LABEL_W] = low_q[f][k];
                hi_flat[k*LABEL_W +: LABEL_W] = high_q[f][k];
            end
        end
        mpls_flow_match #(.NUM_CH(NUM_CH), .CH_W(CH_W)) u_match (
            .labels_in(labels_flat),
            .count_in(count_q),
            .cw_top_in(cw_top_q),
            .cw_seen_in(cw_seen_q),
            .stack_ok_in(!err_q),
            .channel_in(chan_q),
            .enable_in(ctrl_q[f][CTRL_ENABLE]),
            .chan_mask_in(ctrl_q[f][CTRL_CHAN_LSB +: NUM_CH]),
            .cw_expected_in(ctrl_q[f][CTRL_CW]),
            .ref_end_in(ctrl_q[f][CTRL_REF]),
            .depth_mask_in(ctrl_q[f][CTRL_DEPTH_LSB +: 4]),
            .low_in(lo_flat),
            .high_in(hi_flat),
            .match_out(raw_match[f])
        );
    end

    // Lowest matching flow decides offset and next-protocol set
    logic [FI_W-1:0] first_idx;
    logic [NUM_FLOWS-1:0] first_hot;
    always_comb
    begin
        first_idx = '0;
        first_hot = '0;
        for (int f = NUM_FLOWS - 1; f >= 0; f--)
        begin
            if (raw_match[f])
            begin
                first_idx = FI_W'(f);
                first_hot = NUM_FLOWS'(1) << f;
            end
        end
    end

    // Offset counts labels, plus the control word when the chosen flow expects one
    wire first_cw = ctrl_q[first_idx][CTRL_CW];
    wire [OFF_W-1:0] label_bytes = OFF_W'({count_q, 2'b00});
    wire [OFF_W-1:0] cw_bytes = first_cw ? (OFF_W'(1) << WORD_BYTES_SHIFT) : '0;
    wire [OFF_W-1:0] offset_d = base_q + label_bytes + cw_bytes;
    wire [NUM_FLOWS-1:0] match_d = (match_mode_q == MODE_FIRST) ? first_hot : raw_match;

    // Result registers, loaded two cycles after the stack is judged
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            result_valid_out <= 1'b0;
            flow_match_out <= '0;
            stack_error_out <= 1'b0;
            label_count_out <= 3'h0;
            next_offset_out <= '0;
            next_comparator_out <= NEXT_CMP_RST;
            next_set_out <= 1'b0;
        end
        else
        begin
            result_valid_out <= eval_q;
            if (eval_q)
            begin
                flow_match_out <= match_d;
                stack_error_out <= err_q;
                label_count_out <= count_q;
                next_offset_out <= offset_d;
                next_comparator_out <= next_cmp_q;
                next_set_out <= ctrl_q[first_idx][CTRL_SET];
            end
        end
    end

    // Checks on the design's own behaviour
    logic [NUM_FLOWS-1:0] enables;
    always_comb
    begin
        for (int f = 0; f < NUM_FLOWS; f++)
            enables[f] = ctrl_q[f][CTRL_ENABLE];
    end

    property p_count_range;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        result_valid_out && !stack_error_out |-> label_count_out >= 3'h1 &&
            label_count_out <= 3'h4;
    endproperty
    a_count_range: assert property (p_count_range)
        else $error("label count outside one to four");

    property p_bos_stops;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        label_word && bos && !at_max |=> state_q != ST_LABELS;
    endproperty
    a_bos_stops: assert property (p_bos_stops)
        else $error("walk continued past bottom label");

    property p_eval_latency;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        go_eval |-> ##2 result_valid_out;
    endproperty
    a_eval_latency: assert property (p_eval_latency)
        else $error("result not given two cycles after judgement");

    property p_offset;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        eval_q |=> next_offset_out == $past(base_q) + OFF_W'({$past(count_q), 2'b00}) +
            ($past(first_cw) ? OFF_W'(4) : OFF_W'(0));
    endproperty
    a_offset: assert property (p_offset)
        else $error("next protocol offset wrong");

    property p_disabled_quiet;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        eval_q |=> (flow_match_out & ~$past(enables)) == '0;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("disabled flow reported a match");

    property p_error_no_match;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        result_valid_out && stack_error_out |-> flow_match_out == '0;
    endproperty
    a_error_no_match: assert property (p_error_no_match)
        else $error("match on a malformed stack");

    property p_next_cmp;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        reg_wr_in && reg_addr_in == ADDR_NEXT_CMP |=> next_cmp_q == $past(reg_wdata_in[2:0]);
    endproperty
    a_next_cmp: assert property (p_next_cmp)
        else $error("next comparator pointer not written");

    property p_depth_mask0;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        eval_q && count_q != 3'h0 && !ctrl_q[0][CTRL_DEPTH_LSB + int'(count_q) - 1]
            |=> !flow_match_out[0];
    endproperty
    a_depth_mask0: assert property (p_depth_mask0)
        else $error("flow 0 matched a disallowed depth");

    property p_cw_nibble0;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        eval_q && ctrl_q[0][CTRL_CW] && (!cw_seen_q || cw_top_q != 4'h0) |=> !flow_match_out[0];
    endproperty
    a_cw_nibble0: assert property (p_cw_nibble0)
        else $error("flow 0 matched a bad control word");

    property p_first_mode;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        eval_q && match_mode_q == MODE_FIRST |=> $onehot0(flow_match_out);
    endproperty
    a_first_mode: assert property (p_first_mode)
        else $error("first-match mode reported several flows");
endmodule : mpls_label_stack_comparator

//--- core/mpls_cmp_pkg.sv
// Constants shared by the label stack comparator and its per-flow matcher
package mpls_cmp_pkg;
    // Stack geometry
    localparam int MAX_LABELS = 4;
    localparam int LABEL_W = 20;
    localparam int WORD_W = 32;
    localparam int LBL_MSB = 31;
    localparam int LBL_LSB = 12;
    localparam int BOS_BIT = 8;
    localparam int CW_TOP_MSB = 31;
    localparam int CW_TOP_LSB = 28;
    localparam logic [2:0] WORD_BYTES_SHIFT = 3'h2;
    // Register map (byte addresses)
    localparam logic [11:0] ADDR_MATCH_MODE = 12'h000;
    localparam logic [11:0] ADDR_NEXT_CMP = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [2:0] FLOW_REGION = 3'h1;
    localparam int FLOW_REGION_LSB = 9;
    localparam int FLOW_IDX_LSB = 6;
    localparam logic [3:0] FW_CTRL = 4'h0;
    localparam logic [3:0] FW_LOW0 = 4'h1;
    localparam logic [3:0] FW_HIGH0 = 4'h5;
    localparam logic [3:0] FW_LAST = 4'h8;
    // Per-flow control word fields
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_CW = 1;
    localparam int CTRL_REF = 2;
    localparam int CTRL_SET = 3;
    localparam int CTRL_DEPTH_LSB = 4;
    localparam int CTRL_CHAN_LSB = 8;
    localparam int CTRL_W = 16;
    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;
    localparam logic [19:0] BOUND_LOW_RST = 20'h00000;
    localparam logic [19:0] BOUND_HIGH_RST = 20'hfffff;
    localparam logic [2:0] NEXT_CMP_RST = 3'h0;
    localparam logic MATCH_MODE_RST = 1'b0;
    // Match modes
    localparam logic MODE_ALL = 1'b0;
    localparam logic MODE_FIRST = 1'b1;
    typedef enum logic [1:0] {ST_IDLE, ST_LABELS, ST_CTRLW} parse_state_t;
endpackage : mpls_cmp_pkg

//--- core/mpls_flow_match.sv
// One flow's depth, label range and control word check
`timescale 1ns/10ps
module mpls_flow_match
    import mpls_cmp_pkg::*;
#(
    parameter int NUM_CH = 4,
    parameter int CH_W = 2
)(
    input wire logic [MAX_LABELS*LABEL_W-1:0] labels_in,
    input wire logic [2:0] count_in,
    input wire logic [3:0] cw_top_in,
    input wire logic cw_seen_in,
    input wire logic stack_ok_in,
    input wire logic [CH_W-1:0] channel_in,
    input wire logic enable_in,
    input wire logic [NUM_CH-1:0] chan_mask_in,
    input wire logic cw_expected_in,
    input wire logic ref_end_in,
    input wire logic [3:0] depth_mask_in,
    input wire logic [MAX_LABELS*LABEL_W-1:0] low_in,
    input wire logic [MAX_LABELS*LABEL_W-1:0] high_in,
    output logic match_out
);
    logic [MAX_LABELS-1:0] entry_ok;
    logic depth_ok;
    logic cw_ok;
    logic chan_ok;

    // Map each range entry onto a stack position from the top or from the end
    always_comb
    begin
        int pos;
        logic [LABEL_W-1:0] lbl;
        pos = 0;
        lbl = '0;
        for (int k = 0; k < MAX_LABELS; k++)
        begin
            if (ref_end_in)
                pos = int'(count_in) - MAX_LABELS + k;
            else
                pos = k;
            if (pos < 0 || pos >= int'(count_in))
                entry_ok[k] = 1'b1; // Position absent in a short stack
            else
            begin
                lbl = labels_in[pos*LABEL_W +: LABEL_W];
                entry_ok[k] = (lbl >= low_in[k*LABEL_W +: LABEL_W]) &&
                    (lbl <= high_in[k*LABEL_W +: LABEL_W]);
            end
        end
    end

    // Depth n+1 allowed when mask bit n set; a zero count never matches
    assign depth_ok = (count_in != 3'h0) && depth_mask_in[count_in[1:0] - 2'h1];
    // Non-ACH control word: only the top nibble is checked, must be zero
    assign cw_ok = !cw_expected_in || (cw_seen_in && cw_top_in == 4'h0);
    assign chan_ok = chan_mask_in[channel_in];
    assign match_out = stack_ok_in && enable_in && chan_ok && depth_ok && cw_ok &&
        (&entry_ok);
endmodule : mpls_flow_match

//--- test/stack_word_source.sv
// Upstream stage model that hands label stack words to the comparator
`timescale 1ns/10ps
module stack_word_source (
    input wire logic clk_sys_in,
    output logic word_valid_out,
    output logic start_out,
    output logic last_out,
    output logic [31:0] word_out,
    output logic [1:0] channel_out,
    output logic [7:0] base_offset_out
);
    initial
    begin
        word_valid_out = 1'b0;
        start_out = 1'b0;
        last_out = 1'b0;
        word_out = 32'h0;
        channel_out = 2'h0;
        base_offset_out = 8'h00;
    end
    // One word after an optional idle gap; the header before the stack is already checked
    task automatic send(input logic [31:0] w, input logic st, input logic ls,
        input logic [1:0] ch, input logic [7:0] base, input int gap);
        repeat (gap) @(posedge clk_sys_in);
        @(posedge clk_sys_in);
        word_valid_out <= 1'b1;
        start_out <= st;
        last_out <= ls;
        word_out <= w;
        channel_out <= ch;
        base_offset_out <= base;
        @(posedge clk_sys_in);
        // Valid and markers drop, data lines show the inverse so that stale data is never trusted
        word_valid_out <= 1'b0;
        start_out <= 1'b0;
        last_out <= 1'b0;
        word_out <= ~w;
        channel_out <= ~ch;
        base_offset_out <= ~base;
    endtask : send
endmodule : stack_word_source

//--- test/mpls_label_stack_comparator_test.sv
// Random self-checking bench for the label stack comparator
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module mpls_label_stack_comparator_test
    import mpls_cmp_pkg::*;
;
    logic clk_sys_in = 1'b0;
    logic rst_n_in;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] rdata;
    logic word_valid;
    logic start;
    logic last;
    logic [31:0] word;
    logic [1:0] channel;
    logic [7:0] base_offset;
    logic result_valid;
    logic stack_error;
    logic next_set;
    logic [7:0] flow_match;
    logic [7:0] next_offset;
    logic [2:0] label_count;
    logic [2:0] next_cmp;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [15:0] seed = 16'h001b;
    logic [15:0] cfg [8];
    int lo [8][4];
    int hi [8][4];
    int lab [5];

    mpls_label_stack_comparator i_mpls_label_stack_comparator (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(rdata), .word_valid_in(word_valid), .start_in(start),
        .last_in(last), .word_in(word), .channel_in(channel), .base_offset_in(base_offset),
        .result_valid_out(result_valid), .flow_match_out(flow_match),
        .stack_error_out(stack_error), .label_count_out(label_count),
        .next_offset_out(next_offset), .next_comparator_out(next_cmp), .next_set_out(next_set)
    );
    stack_word_source i_stack_word_source (
        .clk_sys_in(clk_sys_in), .word_valid_out(word_valid), .start_out(start),
        .last_out(last), .word_out(word), .channel_out(channel), .base_offset_out(base_offset)
    );

    initial
    begin
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction : rnd

    function automatic logic [11:0] fa(input int f, input int off);
        return 12'h200 + 12'(f * 64 + off);
    endfunction : fa

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys_in);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data is registered on the strobe edge and held until the next read, so sample just past that edge
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk_sys_in);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys_in);
        reg_rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // Cut a hang short well beyond the expected run length
    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    initial
    begin
        logic [31:0] d;
        logic [31:0] w;
        logic [15:0] r;
        logic [3:0] cwtop;
        logic [7:0] m;
        logic ok;
        logic mode;
        logic [2:0] ptr;
        int n, nl, err, cwp, ch, base, sel, f, k, i, idx, it;
        logic [11:0] ra [6];
        logic [31:0] rv [6];
        ra = '{fa(3, 0), fa(3, 12), fa(3, 24), ADDR_NEXT_CMP, ADDR_MATCH_MODE, 12'h224};
        rv = '{{16'h0, CTRL_RST}, {12'h0, BOUND_LOW_RST}, {12'h0, BOUND_HIGH_RST}, 32'h0, 32'h0, 32'h0};
        rst_n_in = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 32'h0;
        repeat (2) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        // Reset values and an unmapped place
        for (k = 0; k < 6; k++)
        begin
            rd(ra[k], d);
            `CHK(d, rv[k])
        end
        for (it = 0; it < 60; it++)
        begin
            r = rnd();
            mode = r[15];
            ptr = 3'(rnd());
            wr(ADDR_MATCH_MODE, {31'h0, mode});
            wr(ADDR_NEXT_CMP, {29'h0, ptr});
            // Fresh per-flow settings, some positions left as don't care
            for (f = 0; f < 8; f++)
            begin
                r = rnd();
                cfg[f] = {4'h0, r[11:1], r[15:12] != 4'h0};
                wr(fa(f, 0), {16'h0, cfg[f]});
                for (k = 0; k < 4; k++)
                begin
                    r = rnd();
                    lo[f][k] = r[0] ? 0 : int'(r[4:1]);
                    hi[f][k] = r[0] ? 20'hfffff : lo[f][k] + int'(r[7:5]);
                    wr(fa(f, 4 + 4 * k), 32'(lo[f][k]));
                    wr(fa(f, 20 + 4 * k), 32'(hi[f][k]));
                end
            end
            rd(fa(it % 8, 0), d);
            `CHK(d, {16'h0, cfg[it % 8]})
            r = rnd();
            n = 1 + int'(r[1:0]);
            err = r[4:2] < 3'h2;
            nl = r[4:2] == 3'h0 ? 5 : n;
            cwp = !err && r[5];
            cwtop = r[8:6] == 3'h0 ? r[12:9] | 4'h1 : 4'h0;
            ch = int'(r[14:13]);
            base = int'(rnd() >> 8);
            // A word without a start marker must be ignored
            if (r[15])
                i_stack_word_source.send(32'hffffffff, 1'b0, 1'b1, 2'(ch), 8'(base), 0);
            for (i = 0; i < nl; i++)
            begin
                lab[i] = int'(rnd() % 16);
                // Label field sits in bits 31:12, so the small value lands at 15:12
                w = {16'h0, 4'(lab[i]), 12'(rnd())};
                w[BOS_BIT] = !err && i == n - 1;
                i_stack_word_source.send(w, i == 0, i == nl - 1 && !cwp, 2'(ch), 8'(base),
                    int'(rnd() % 3));
            end
            if (cwp)
                i_stack_word_source.send({cwtop, 28'(rnd())}, 1'b0, 1'b1, 2'(ch), 8'(base), 0);
            // The result pulse rises on the edge after the one the last word returned on
            #1;
            for (k = 0; k < 8 && result_valid !== 1'b1; k++)
            begin
                @(posedge clk_sys_in);
                #1;
            end
            `CHK(result_valid, 1'b1)
            `CHK(stack_error, 1'(err))
            if (!err)
            begin
                // Reference model of every flow
                m = 8'h00;
                for (f = 0; f < 8; f++)
                begin
                    ok = cfg[f][0] && cfg[f][8 + ch] && cfg[f][3 + n];
                    ok = ok && (!cfg[f][1] || (cwp && cwtop == 4'h0));
                    for (k = 0; k < 4; k++)
                    begin
                        idx = cfg[f][2] ? n - 4 + k : k;
                        if (idx >= 0 && idx < n && (lab[idx] < lo[f][k] || lab[idx] > hi[f][k]))
                            ok = 1'b0;
                    end
                    m[f] = ok;
                end
                sel = 0;
                for (f = 7; f >= 0; f--)
                    if (m[f])
                        sel = f;
                if (mode)
                    m = m & (8'h01 << sel);
                `CHK(flow_match, m)
                `CHK(label_count, 3'(n))
                `CHK(next_offset, 8'(base + 4 * n + (cfg[sel][1] ? 4 : 0)))
                `CHK(next_cmp, ptr)
                `CHK(next_set, cfg[sel][3])
                rd(ADDR_STATUS, d);
                `CHK(d[4:0], {1'b0, 1'(cwp), 3'(n)})
            end
        end
        print_verdict();
    end
endmodule : mpls_label_stack_comparator_test
